// ---- design/adc_sel_pkg.sv ----
// package: register map, field layout and reset values of the input select block
package adc_sel_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] OFS_CH0_SEL    = 8'h00;
  localparam logic [7:0] OFS_SCAN_HIGH  = 8'h04;
  localparam logic [7:0] OFS_SCAN_LOW   = 8'h08;
  localparam logic [7:0] OFS_PMODE_HIGH = 8'h0C;
  localparam logic [7:0] OFS_PMODE_LOW  = 8'h10;
  localparam logic [7:0] OFS_CONTROL    = 8'h14;
  localparam logic [7:0] OFS_STATUS     = 8'h18;
  // channel 0 select fields
  localparam int POS_A_LSB = 0;
  localparam int NEG_A_BIT = 7;
  localparam int POS_B_LSB = 8;
  localparam int NEG_B_BIT = 15;
  localparam logic [15:0] CH0_MASK_FULL   = 16'h9F9F;
  localparam logic [15:0] CH0_MASK_SECOND = 16'h8F8F;
  // control fields
  localparam int ALT_BIT  = 0;
  localparam int SCAN_BIT = 10;
  localparam logic [15:0] CONTROL_MASK = 16'h0401;
  // status fields
  localparam int STAT_SAMPLE_B_BIT = 8;
  // reset values
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [4:0]  PTR_RESET = 5'h00;
  // counts
  localparam int NUM_INPUTS = 32;
  localparam int HALF       = 16;
endpackage : adc_sel_pkg

// ---- design/adc_input_select.sv ----
// analog input select, scan select and pin mode registers of one converter unit
//
// Design decisions made here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
module adc_input_select #(
  parameter bit SECOND_UNIT    = 1'b0,
  parameter int PRESENT_INPUTS = 32
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // avalon-mm slave
  input  wire logic [7:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [3:0]  byteenable_i,
  input  wire logic [31:0] writedata_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  // sequencer side
  input  wire logic        sample_done_i,
  input  wire logic [15:0] peer_pin_mode_low_i,
  output logic      [15:0] pin_mode_low_o,
  // multiplexer and pin side
  output logic      [4:0]  pos_input_o,
  output logic             neg_is_input1_o,
  output logic             use_low_ref_o,
  output logic             mux_ground_o,
  output logic      [31:0] pin_digital_o
);

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_type;

  localparam logic [15:0] CH0_MASK =
    SECOND_UNIT ? adc_sel_pkg::CH0_MASK_SECOND : adc_sel_pkg::CH0_MASK_FULL;

  // next set bit above cur, wrapping; cur when mask empty
  function automatic logic [4:0] next_scan(input logic [31:0] mask, input logic [4:0] cur);
    logic [4:0] idx;
    logic       found;
    next_scan = cur;
    found     = 1'b0;
    for (int k = 1; k <= adc_sel_pkg::NUM_INPUTS; k++) begin
      idx = 5'(int'(cur) + k);
      if (!found && mask[idx]) begin
        next_scan = idx;
        found     = 1'b1;
      end
    end
  endfunction : next_scan

  // write merge honouring the two low byte lanes
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (be[0]) v[7:0] = wd[7:0];
    if (be[1]) v[15:8] = wd[15:8];
    merge = v & mask;
  endfunction : merge

  bus_state_type bus_state, next_bus_state;
  logic [31:0]   readdata, next_readdata;
  logic [15:0]   ch0_input_select, next_ch0_input_select;
  logic [15:0]   scan_select_high, next_scan_select_high;
  logic [15:0]   scan_select_low, next_scan_select_low;
  logic [15:0]   pin_mode_high, next_pin_mode_high;
  logic [15:0]   pin_mode_low, next_pin_mode_low;
  logic [15:0]   control, next_control;
  logic          sample_b, next_sample_b;
  logic [4:0]    scan_ptr, next_scan_ptr;
  logic [4:0]    pos_input, next_pos_input;
  logic          neg_is_input1, next_neg_is_input1;
  logic          use_low_ref, next_use_low_ref;
  logic          mux_ground, next_mux_ground;
  logic [31:0]   pin_digital, next_pin_digital;
  logic [31:0]   present;
  logic [31:0]   scan_include_bits;
  logic [31:0]   pin_digital_mode_bits;
  logic          scan_enable;
  logic          alternate_sample_enable;
  logic          req;

  // which inputs exist on this part
  for (genvar g = 0; g < adc_sel_pkg::NUM_INPUTS; g++) begin : g_present
    assign present[g] = (g < PRESENT_INPUTS);
  end

  assign req                     = read_i | write_i;
  // high word scans 16..31, low word 0..15
  assign scan_include_bits       = {scan_select_high, scan_select_low};
  assign pin_digital_mode_bits   = {pin_mode_high, pin_mode_low};
  assign scan_enable             = control[adc_sel_pkg::SCAN_BIT];
  assign alternate_sample_enable = control[adc_sel_pkg::ALT_BIT];

  // request stalls one cycle so read data can be registered
  assign waitrequest_o = req & (bus_state == BUS_IDLE);

  // bus and register next values
  always_comb begin
    next_bus_state        = BUS_IDLE;
    next_readdata         = readdata;
    next_ch0_input_select = ch0_input_select;
    next_scan_select_high = scan_select_high;
    next_scan_select_low  = scan_select_low;
    next_pin_mode_high    = pin_mode_high;
    next_pin_mode_low     = pin_mode_low;
    next_control          = control;
    unique case (bus_state)
      BUS_IDLE: begin
        if (req) begin
          next_bus_state = BUS_ACK;
          next_readdata  = 32'h0000_0000;
          if (read_i) begin
            unique case (address_i)
              adc_sel_pkg::OFS_CH0_SEL:    next_readdata[15:0] = ch0_input_select;
              adc_sel_pkg::OFS_SCAN_HIGH:  next_readdata[15:0] = scan_select_high;
              adc_sel_pkg::OFS_SCAN_LOW:   next_readdata[15:0] = scan_select_low;
              adc_sel_pkg::OFS_PMODE_HIGH: next_readdata[15:0] = pin_mode_high;
              adc_sel_pkg::OFS_PMODE_LOW:  next_readdata[15:0] = pin_mode_low;
              adc_sel_pkg::OFS_CONTROL:    next_readdata[15:0] = control;
              adc_sel_pkg::OFS_STATUS: begin
                next_readdata[4:0] = pos_input;
                next_readdata[adc_sel_pkg::STAT_SAMPLE_B_BIT] = sample_b;
              end
              default: next_readdata = 32'h0000_0000;
            endcase
          end
        end
      end
      BUS_ACK: begin
        // write lands at the edge where waitrequest is seen low
        if (write_i) begin
          unique case (address_i)
            adc_sel_pkg::OFS_CH0_SEL:
              next_ch0_input_select = merge(ch0_input_select, writedata_i, byteenable_i, CH0_MASK);
            adc_sel_pkg::OFS_SCAN_HIGH:
              next_scan_select_high = merge(scan_select_high, writedata_i, byteenable_i, 16'hFFFF);
            adc_sel_pkg::OFS_SCAN_LOW:
              next_scan_select_low = merge(scan_select_low, writedata_i, byteenable_i, 16'hFFFF);
            // high pin mode absent in second unit
            adc_sel_pkg::OFS_PMODE_HIGH:
              next_pin_mode_high = merge(pin_mode_high, writedata_i, byteenable_i,
                                         SECOND_UNIT ? 16'h0000 : 16'hFFFF);
            adc_sel_pkg::OFS_PMODE_LOW:
              next_pin_mode_low = merge(pin_mode_low, writedata_i, byteenable_i, 16'hFFFF);
            adc_sel_pkg::OFS_CONTROL:
              next_control = merge(control, writedata_i, byteenable_i, adc_sel_pkg::CONTROL_MASK);
            default: next_control = control;
          endcase
        end
      end
      default: next_bus_state = BUS_IDLE;
    endcase
  end

  // bus and register flops
  // registers zero at reset, bus state to BUS_IDLE
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bus_state        <= BUS_IDLE;
      readdata         <= 32'h0000_0000;
      ch0_input_select <= adc_sel_pkg::REG_RESET;
      scan_select_high <= adc_sel_pkg::REG_RESET;
      scan_select_low  <= adc_sel_pkg::REG_RESET;
      pin_mode_high    <= adc_sel_pkg::REG_RESET;
      pin_mode_low     <= adc_sel_pkg::REG_RESET;
      control          <= adc_sel_pkg::REG_RESET;
    end else begin
      bus_state        <= next_bus_state;
      readdata         <= next_readdata;
      ch0_input_select <= next_ch0_input_select;
      scan_select_high <= next_scan_select_high;
      scan_select_low  <= next_scan_select_low;
      pin_mode_high    <= next_pin_mode_high;
      pin_mode_low     <= next_pin_mode_low;
      control          <= next_control;
    end
  end

  assign readdata_o     = readdata;
  assign pin_mode_low_o = pin_mode_low;

  // sample sequencing and mux selection
  always_comb begin
    next_sample_b = sample_b;
    next_scan_ptr = scan_ptr;
    if (sample_done_i) begin
      next_sample_b = alternate_sample_enable & ~sample_b;
      if (scan_enable && !sample_b) begin
        next_scan_ptr = next_scan(scan_include_bits, scan_ptr);
      end
    end else if (!alternate_sample_enable) begin
      next_sample_b = 1'b0;
    end
    if (!scan_enable) begin
      next_scan_ptr = next_scan(scan_include_bits, 5'd31);
    end
    if (sample_b) begin
      next_pos_input = ch0_input_select[adc_sel_pkg::POS_B_LSB +: 5];
    end else if (scan_enable) begin
      next_pos_input = scan_ptr;
    end else begin
      next_pos_input = ch0_input_select[adc_sel_pkg::POS_A_LSB +: 5];
    end
    // second unit cannot reach inputs above 15
    if (SECOND_UNIT) begin
      next_pos_input[4] = 1'b0;
    end
    next_neg_is_input1 = sample_b ? ch0_input_select[adc_sel_pkg::NEG_B_BIT]
                                  : ch0_input_select[adc_sel_pkg::NEG_A_BIT];
    next_use_low_ref = ~present[next_pos_input];
    // either unit may force low pins digital
    next_pin_digital = pin_digital_mode_bits | {16'h0000, peer_pin_mode_low_i};
    // absent pins ignore their mode bits
    next_pin_digital = next_pin_digital & present;
    // digital pin grounds the mux input
    next_mux_ground = next_pin_digital[next_pos_input];
  end

  // sequencing and output flops
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sample_b      <= 1'b0;
      scan_ptr      <= adc_sel_pkg::PTR_RESET;
      pos_input     <= adc_sel_pkg::PTR_RESET;
      neg_is_input1 <= 1'b0;
      use_low_ref   <= 1'b0;
      mux_ground    <= 1'b0;
      pin_digital   <= 32'h0000_0000;
    end else begin
      sample_b      <= next_sample_b;
      scan_ptr      <= next_scan_ptr;
      pos_input     <= next_pos_input;
      neg_is_input1 <= next_neg_is_input1;
      use_low_ref   <= next_use_low_ref;
      mux_ground    <= next_mux_ground;
      pin_digital   <= next_pin_digital;
    end
  end

  assign pos_input_o     = pos_input;
  assign neg_is_input1_o = neg_is_input1;
  assign use_low_ref_o   = use_low_ref;
  assign mux_ground_o    = mux_ground;
  assign pin_digital_o   = pin_digital;

  // checks on the register file and selection path
  property p_ch0_write;
    @(posedge clock_i) disable iff (rst_i)
    (bus_state == BUS_ACK && write_i && address_i == adc_sel_pkg::OFS_CH0_SEL && byteenable_i[1:0] == 2'b11)
      |=> ch0_input_select == ($past(writedata_i[15:0]) & CH0_MASK);
  endproperty
  a_ch0_write: assert property (p_ch0_write) else $error("ch0 select write lost");

  property p_unimpl_zero;
    @(posedge clock_i) disable iff (rst_i)
    $past(read_i && bus_state == BUS_IDLE && address_i == adc_sel_pkg::OFS_CH0_SEL)
      |-> readdata_o[14:13] == 2'b00 && readdata_o[6:5] == 2'b00;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits read nonzero");

  property p_alternate;
    @(posedge clock_i) disable iff (rst_i)
    sample_done_i && alternate_sample_enable |=> sample_b != $past(sample_b);
  endproperty
  a_alternate: assert property (p_alternate) else $error("sample B did not alternate");

  property p_no_alternate;
    @(posedge clock_i) disable iff (rst_i)
    !alternate_sample_enable ##1 !alternate_sample_enable |-> !sample_b;
  endproperty
  a_no_alternate: assert property (p_no_alternate) else $error("sample B used without alternation");

  property p_scan_hit;
    @(posedge clock_i) disable iff (rst_i)
    scan_enable && scan_include_bits != 32'h0000_0000 && sample_done_i && !sample_b
      |=> $past(scan_include_bits[next_scan_ptr]);
  endproperty
  a_scan_hit: assert property (p_scan_hit) else $error("scan stopped on unselected input");

  property p_scan_drive;
    @(posedge clock_i) disable iff (rst_i)
    scan_enable && !sample_b && !SECOND_UNIT |=> pos_input_o == $past(scan_ptr);
  endproperty
  a_scan_drive: assert property (p_scan_drive) else $error("scan pointer not on mux");

  property p_second_limit;
    @(posedge clock_i) disable iff (rst_i)
    SECOND_UNIT |-> pos_input_o[4] == 1'b0;
  endproperty
  a_second_limit: assert property (p_second_limit) else $error("second unit above input 15");

  property p_ground;
    @(posedge clock_i) disable iff (rst_i)
    mux_ground_o |-> pin_digital_o[pos_input_o] && !use_low_ref_o;
  endproperty
  a_ground: assert property (p_ground) else $error("mux grounded on analog pin");

  property p_neg_a;
    @(posedge clock_i) disable iff (rst_i)
    !sample_b |=> neg_is_input1_o == $past(ch0_input_select[adc_sel_pkg::NEG_A_BIT]);
  endproperty
  a_neg_a: assert property (p_neg_a) else $error("negative select A mismatch");

  c_scan: cover property (@(posedge clock_i) disable iff (rst_i) scan_enable && sample_done_i ##1 sample_done_i);
  c_alt: cover property (@(posedge clock_i) disable iff (rst_i) sample_b ##1 !sample_b);
  c_ground: cover property (@(posedge clock_i) disable iff (rst_i) mux_ground_o);
  c_low_ref: cover property (@(posedge clock_i) disable iff (rst_i) use_low_ref_o);

endmodule : adc_input_select

// ---- dv/seq_model.sv ----
// partner model: sequencer stand-in giving sample pulses and the peer unit pin modes
`timescale 1ns/1ns
module seq_model (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // bench control
  input  wire logic        fire_i,
  input  wire logic [3:0]  delay_i,
  input  wire logic [15:0] peer_i,
  // towards the block
  output logic             sample_done_o,
  output logic      [15:0] peer_pin_mode_low_o
);
  logic [4:0] count;
  logic [4:0] next_count;
  // countdown lets a sample end promptly or late
  always_comb begin
    next_count = count;
    if (fire_i)
      next_count = {1'b0, delay_i} + 5'h01;
    else if (count != 5'h00)
      next_count = count - 5'h01;
  end
  // pulse is one cycle wide, as a real sequencer gives
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      count               <= 5'h00;
      sample_done_o       <= 1'b0;
      peer_pin_mode_low_o <= 16'h0000;
    end else begin
      count               <= next_count;
      sample_done_o       <= (count == 5'h01);
      peer_pin_mode_low_o <= peer_i;
    end
  end
endmodule : seq_model

// ---- dv/adc_input_select_test.sv ----
// testbench: register access, selection outputs, alternate and scan stepping
`timescale 1ns/1ns
module adc_input_select_test;
  localparam int PRES = 24;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  address_i = 8'h00;
  logic        read_i = 1'b0;
  logic        write_i = 1'b0;
  logic [3:0]  byteenable_i = 4'hF;
  logic [31:0] writedata_i = 32'h0000_0000;
  logic [31:0] readdata_o;
  logic        waitrequest_o;
  logic        sample_done;
  logic [15:0] peer_mode;
  logic [15:0] pin_mode_low_o;
  logic [4:0]  pos_input_o;
  logic        neg_is_input1_o;
  logic        use_low_ref_o;
  logic        mux_ground_o;
  logic [31:0] pin_digital_o;
  logic        fire = 1'b0;
  logic [3:0]  delay = 4'h0;
  logic [15:0] peer = 16'h0000;
  logic        unit2 = 1'b0;
  logic [31:0] readdata_1;
  logic [31:0] readdata_2;
  logic        wait_1;
  logic        wait_2;
  logic [4:0]  pos_2;
  logic        neg_2;
  logic        ref_2;
  logic        gnd_2;
  logic [31:0] pins_2;
  logic [31:0] seed = 32'h494b_8cfe;
  logic [15:0] q;
  logic [15:0] r [5];
  int          num_errors = 0;
  int          samples_checked = 0;
  logic [7:0]  offs [5] = '{adc_sel_pkg::OFS_CH0_SEL, adc_sel_pkg::OFS_SCAN_HIGH, adc_sel_pkg::OFS_SCAN_LOW,
                            adc_sel_pkg::OFS_PMODE_HIGH, adc_sel_pkg::OFS_PMODE_LOW};
  logic [15:0] mask [5] = '{adc_sel_pkg::CH0_MASK_FULL, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
  logic [4:0]  scan_seq [4] = '{5'h02, 5'h05, 5'h10, 5'h02};

  adc_input_select #(.SECOND_UNIT(1'b0), .PRESENT_INPUTS(PRES)) i_adc_input_select (
    .clock_i(clock_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i & ~unit2), .write_i(write_i & ~unit2),
    .byteenable_i(byteenable_i), .writedata_i(writedata_i), .readdata_o(readdata_1),
    .waitrequest_o(wait_1), .sample_done_i(sample_done), .peer_pin_mode_low_i(peer_mode),
    .pin_mode_low_o(pin_mode_low_o), .pos_input_o(pos_input_o), .neg_is_input1_o(neg_is_input1_o),
    .use_low_ref_o(use_low_ref_o), .mux_ground_o(mux_ground_o), .pin_digital_o(pin_digital_o));

  // second unit on the same bus, selected by unit2; its peer is the first unit
  adc_input_select #(.SECOND_UNIT(1'b1), .PRESENT_INPUTS(16)) i_adc_input_select_second (
    .clock_i(clock_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i & unit2), .write_i(write_i & unit2),
    .byteenable_i(byteenable_i), .writedata_i(writedata_i), .readdata_o(readdata_2),
    .waitrequest_o(wait_2), .sample_done_i(sample_done), .peer_pin_mode_low_i(pin_mode_low_o),
    .pin_mode_low_o(), .pos_input_o(pos_2), .neg_is_input1_o(neg_2),
    .use_low_ref_o(ref_2), .mux_ground_o(gnd_2), .pin_digital_o(pins_2));

  // bus answer comes from whichever unit is selected
  assign readdata_o    = unit2 ? readdata_2 : readdata_1;
  assign waitrequest_o = unit2 ? wait_2 : wait_1;

  seq_model i_seq_model (.clock_i(clock_i), .rst_i(rst_i), .fire_i(fire), .delay_i(delay), .peer_i(peer),
    .sample_done_o(sample_done), .peer_pin_mode_low_o(peer_mode));

  always #5 clock_i = ~clock_i;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // both units' low modes merge; absent pins never read as digital
  function automatic logic [31:0] exp_pins();
    logic [31:0] p;
    p = {r[3], r[4] | peer};
    for (int i = PRES; i < 32; i++) p[i] = 1'b0;
    return p;
  endfunction : exp_pins

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : check

  // one avalon access; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    read_i <= ~wr;
    write_i <= wr;
    address_i <= a;
    writedata_i <= {16'h0000, d};
    do begin
      @(posedge clock_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 20);
    if (n >= 20) begin
      num_errors++;
      finish_test();
    end
    // data taken at the completing edge, before the flops move
    q = readdata_o[15:0];
    read_i <= 1'b0;
    write_i <= 1'b0;
    check("wait cycles", 32'h0000_0002, n);
    @(posedge clock_i);
  endtask : bus

  task automatic rdc(input string what, input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    check(what, {16'h0000, e}, {16'h0000, q});
  endtask : rdc

  task automatic outs(input logic [4:0] pos, input logic neg);
    logic [31:0] p;
    p = exp_pins();
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    check("pos_input", {27'h0, pos}, {27'h0, pos_input_o});
    check("neg_is_input1", {31'h0, neg}, {31'h0, neg_is_input1_o});
    check("use_low_ref", {31'h0, pos >= PRES}, {31'h0, use_low_ref_o});
    check("mux_ground", {31'h0, p[pos]}, {31'h0, mux_ground_o});
    check("pin_digital", p, pin_digital_o);
    check("pin_mode_low", {16'h0, r[4]}, {16'h0, pin_mode_low_o});
    @(posedge clock_i);
  endtask : outs

  task automatic pulse(input logic [3:0] d);
    fire <= 1'b1;
    delay <= d;
    @(posedge clock_i);
    fire <= 1'b0;
    repeat (d + 5) @(posedge clock_i);
  endtask : pulse

  task automatic reset_and_check();
    rst_i <= 1'b1;
    peer <= 16'h0000;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    for (int k = 0; k < 5; k++) r[k] = 16'h0000;
    for (int k = 0; k < 5; k++) rdc("reset value", offs[k], 16'h0000);
  endtask : reset_and_check

  initial begin
    repeat (50000) @(posedge clock_i);
    num_errors++;
    finish_test();
  end

  initial begin
    reset_and_check();
    // random rounds, the first one all ones to hit input 31
    for (int n = 0; n < 6; n++) begin
      for (int k = 0; k < 5; k++) begin
        r[k] = (n == 0) ? 16'hFFFF : 16'(rnd());
        bus(1'b1, offs[k], r[k]);
        r[k] = r[k] & mask[k];
      end
      peer <= 16'(rnd());
      for (int k = 0; k < 5; k++) rdc("register", offs[k], r[k]);
      outs(r[0][4:0], r[0][7]);
      $display("round %0d done", n);
    end
    // only lane 1 of the low pin mode is written
    byteenable_i <= 4'h2;
    bus(1'b1, adc_sel_pkg::OFS_PMODE_LOW, 16'hFFFF);
    byteenable_i <= 4'hF;
    r[4] = r[4] | 16'hFF00;
    rdc("pin_mode_low", adc_sel_pkg::OFS_PMODE_LOW, r[4]);
    bus(1'b1, 8'h1C, 16'hFFFF);
    rdc("unmapped", 8'h1C, 16'h0000);
    $display("register test done");
    // alternate: A is input 3 on reference, B is input 23 on input 1
    r[0] = 16'h9703;
    bus(1'b1, adc_sel_pkg::OFS_CH0_SEL, r[0]);
    bus(1'b1, adc_sel_pkg::OFS_CONTROL, 16'h0001);
    outs(5'h03, 1'b0);
    pulse(4'h0);
    outs(5'h17, 1'b1);
    pulse(4'h7);
    outs(5'h03, 1'b0);
    bus(1'b1, adc_sel_pkg::OFS_CONTROL, 16'h0000);
    $display("alternate test done");
    // scan over inputs 2, 5 and 16, then wrap
    r[1] = 16'h0001;
    r[2] = 16'h0024;
    bus(1'b1, adc_sel_pkg::OFS_SCAN_HIGH, r[1]);
    bus(1'b1, adc_sel_pkg::OFS_SCAN_LOW, r[2]);
    bus(1'b1, adc_sel_pkg::OFS_CONTROL, 16'h0400);
    for (int s = 0; s < 4; s++) begin
      outs(scan_seq[s], 1'b0);
      if (s < 3) pulse(4'(s * 3));
    end
    rdc("status", adc_sel_pkg::OFS_STATUS, 16'h0002);
    bus(1'b1, adc_sel_pkg::OFS_CONTROL, 16'h0000);
    $display("scan test done");
    // second unit: narrow positive fields, no high pin mode, peer is the first unit
    unit2 <= 1'b1;
    bus(1'b1, adc_sel_pkg::OFS_CH0_SEL, 16'hFFFF);
    rdc("second ch0", adc_sel_pkg::OFS_CH0_SEL, adc_sel_pkg::CH0_MASK_SECOND);
    bus(1'b1, adc_sel_pkg::OFS_PMODE_HIGH, 16'hFFFF);
    rdc("second pin_mode_high", adc_sel_pkg::OFS_PMODE_HIGH, 16'h0000);
    bus(1'b1, adc_sel_pkg::OFS_PMODE_LOW, 16'h8001);
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    check("second pos_input", 32'h0000_000F, {27'h0, pos_2});
    check("second neg_is_input1", 32'h0000_0001, {31'h0, neg_2});
    check("second use_low_ref", 32'h0000_0000, {31'h0, ref_2});
    check("second mux_ground", 32'h0000_0001, {31'h0, gnd_2});
    check("second pin_digital", {16'h0000, r[4] | 16'h8001}, pins_2);
    @(posedge clock_i);
    unit2 <= 1'b0;
    $display("second unit test done");
    reset_and_check();
    $display("second reset test done");
    finish_test();
  end
endmodule : adc_input_select_test
